// ### ccpm_cfg.svh
// Offsets, field positions, codes and reset values of the mode and output unit.
`ifndef CCPM_CFG_SVH
`define CCPM_CFG_SVH

// Register offsets on the plain register port.
`define CCPM_OFS_MODE        4'h0
`define CCPM_OFS_DUTY_HIGH   4'h1
`define CCPM_OFS_CMP_LOW     4'h2
`define CCPM_OFS_CMP_HIGH    4'h3
`define CCPM_OFS_PERIOD      4'h4
`define CCPM_OFS_STATUS      4'h5
`define CCPM_OFS_DRV_EN      4'h6
`define CCPM_OFS_PORT_DATA   4'h7
`define CCPM_OFS_DEADBAND    4'h8
`define CCPM_OFS_TMR_LOW     4'h9
`define CCPM_OFS_TMR_HIGH    4'ha

// Fields of unit_mode_control.
`define CCPM_CFG_MSB         7
`define CCPM_CFG_LSB         6
`define CCPM_DUTY_LO_MSB     5
`define CCPM_DUTY_LO_LSB     4
`define CCPM_SEL_MSB         3
`define CCPM_SEL_LSB         0

// Fields of the status register.
`define CCPM_ST_EVENT        0
`define CCPM_ST_PERIOD       1

// Mode select codes.
`define CCPM_M_OFF           4'h0
`define CCPM_M_TOGGLE        4'h2
`define CCPM_M_CAP_FALL      4'h4
`define CCPM_M_CAP_RISE      4'h5
`define CCPM_M_CAP_RISE4     4'h6
`define CCPM_M_CAP_RISE16    4'h7
`define CCPM_M_CMP_SET       4'h8
`define CCPM_M_CMP_CLR       4'h9
`define CCPM_M_CMP_IRQ       4'ha
`define CCPM_M_CMP_TRIG      4'hb
`define CCPM_M_PWM_TOP       2'h3

// Capture prescale masks.
`define CCPM_PRE4_MASK       4'h3
`define CCPM_PRE16_MASK      4'hf

// Reset values.
`define CCPM_RST_MODE        8'h00
`define CCPM_RST_BYTE        8'h00
`define CCPM_RST_PERIOD      8'hff
`define CCPM_RST_NIBBLE      4'h0

`endif

// ### ccpm_pkg.sv
// Types shared by the mode and output unit.
package ccpm_pkg;

   typedef enum logic [1:0] {
      CCPM_OUT_SINGLE  = 2'h0,
      CCPM_OUT_FB_FWD  = 2'h1,
      CCPM_OUT_HALF    = 2'h2,
      CCPM_OUT_FB_REV  = 2'h3
   } ccpm_outcfg_e;

   typedef logic [7:0] ccpm_byte_t;

endpackage

// ### ccpm_mode_output_config.sv
// Capture, compare and bridge PWM unit with mode and output steering control.
//
// Functional notes
// - Mode zero switches off and resets unit.
// - Toggle mode inverts pin on each match.
// - Capture on falling, rising, 4th, 16th edge.
// - Set mode: pin starts low, match sets.
// - Clear mode: pin starts high, match clears.
// - Interrupt-only mode: flag only, port owns pin.
// - Trigger mode: reset timer, flag, start conversion.
// - Simple instance: no config bits, 11xx is PWM.
// - Enhanced PWM codes set A/C, B/D polarity.
// - Outside PWM, A is unit pin in toggle, set and clear modes, port otherwise; others port.
// - Single output: only A modulated.
// - Forward bridge: D modulated, A active.
// - Half bridge: A, B complementary with dead band.
// - Reverse bridge: B modulated, C active.
// - Duty is ten bits: high byte, low two.
// - Control layout: config, duty low, mode; reset zero.
// - Period flag set as second period begins.
// - Pins stay high impedance until drivers enabled.
`timescale 1ns/100ps
`include "ccpm_cfg.svh"

module ccpm_mode_output_config
   import ccpm_pkg::*;
#(
   parameter bit ENHANCED = 1'b1
) (
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Register port.
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Converter trigger.
   input  wire logic       adc_enable,
   output logic            adc_start,
   // Unit pins.
   input  wire logic       output_a_i,
   output logic            output_a_o,
   output logic            output_a_oe,
   output logic            output_b_o,
   output logic            output_b_oe,
   output logic            output_c_o,
   output logic            output_c_oe,
   output logic            output_d_o,
   output logic            output_d_oe
);

   // Software registers.
   logic [1:0]  output_config_select;
   logic [1:0]  duty_low_bits;
   logic [3:0]  unit_mode_select;
   ccpm_byte_t  duty_high_byte;
   logic [15:0] cmp_val_reg;
   ccpm_byte_t  period_reg;
   logic [3:0]  drv_en_reg;
   logic [3:0]  port_data_reg;
   logic [6:0]  deadband_reg;
   logic        unit_event_flag;
   logic        period_timer_flag;

   // Unit state.
   logic [15:0] tmr_reg;
   logic [3:0]  cap_cnt_reg;
   logic        cmp_pin_reg;
   logic [9:0]  pwm_cnt_reg;
   logic [9:0]  duty_act_reg;
   logic        pwm_raw_reg;
   logic [6:0]  db_cnt_reg;
   logic        pin_sync1_reg;
   logic        pin_sync2_reg;
   logic        pin_prev_reg;
   logic        raw_prev_reg;

   // Decoded control.
   logic        wr_mode;
   logic        is_pwm;
   logic        is_capture;
   logic        is_cmp_pin;
   logic        is_compare;
   logic        cmp_match;
   logic        cap_edge;
   logic        cap_event;
   logic        cmp_event;
   logic        pwm_roll;
   logic        pol_ac_low;
   logic        pol_bd_low;
   logic        clr_event;
   logic        clr_period;
   logic [9:0]  duty_full;
   logic [3:0]  unit_own;
   logic [3:0]  unit_val;
   logic        act_a;
   logic        act_b;

   assign wr_mode    = reg_wr && (reg_addr == `CCPM_OFS_MODE);
   assign is_pwm     = (unit_mode_select[3:2] == `CCPM_M_PWM_TOP);
   assign is_capture = (unit_mode_select[3:2] == 2'h1);
   assign is_cmp_pin = (unit_mode_select == `CCPM_M_TOGGLE) ||
                       (unit_mode_select == `CCPM_M_CMP_SET) ||
                       (unit_mode_select == `CCPM_M_CMP_CLR);
   // Reserved codes fall in none of the classes and so drive nothing.
   assign is_compare = is_cmp_pin ||
                       (unit_mode_select == `CCPM_M_CMP_IRQ) ||
                       (unit_mode_select == `CCPM_M_CMP_TRIG);
   assign cmp_match  = is_compare && (tmr_reg == cmp_val_reg);
   assign cmp_event  = cmp_match && (unit_mode_select != `CCPM_M_TOGGLE);
   assign duty_full  = {duty_high_byte, duty_low_bits};
   assign pwm_roll   = is_pwm && (pwm_cnt_reg[9:2] == period_reg) &&
                       (pwm_cnt_reg[1:0] == 2'h3);
   // A simple instance has no polarity choice and is always active high.
   assign pol_ac_low = ENHANCED && unit_mode_select[1];
   assign pol_bd_low = ENHANCED && unit_mode_select[0];
   assign clr_event  = reg_wr && (reg_addr == `CCPM_OFS_STATUS) &&
                       reg_wdata[`CCPM_ST_EVENT];
   assign clr_period = reg_wr && (reg_addr == `CCPM_OFS_STATUS) &&
                       reg_wdata[`CCPM_ST_PERIOD];

   // Capture edge selection; the first sync stage feeds only the second.
   always_comb begin
      cap_edge = 1'b0;
      case (unit_mode_select)
         `CCPM_M_CAP_FALL:   cap_edge = pin_prev_reg && !pin_sync2_reg;
         `CCPM_M_CAP_RISE,
         `CCPM_M_CAP_RISE4,
         `CCPM_M_CAP_RISE16: cap_edge = !pin_prev_reg && pin_sync2_reg;
         default:            cap_edge = 1'b0;
      endcase
   end

   always_comb begin
      cap_event = 1'b0;
      case (unit_mode_select)
         `CCPM_M_CAP_RISE4:  cap_event = cap_edge &&
                                ((cap_cnt_reg & `CCPM_PRE4_MASK) == `CCPM_PRE4_MASK);
         `CCPM_M_CAP_RISE16: cap_event = cap_edge &&
                                (cap_cnt_reg == `CCPM_PRE16_MASK);
         default:            cap_event = cap_edge;
      endcase
   end

   // Control register.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         {output_config_select, duty_low_bits, unit_mode_select} <= `CCPM_RST_MODE;
      end else if (wr_mode) begin
         // The simple instance has no configuration bits to hold.
         output_config_select <= ENHANCED ?
                                 reg_wdata[`CCPM_CFG_MSB:`CCPM_CFG_LSB] : 2'h0;
         duty_low_bits        <= reg_wdata[`CCPM_DUTY_LO_MSB:`CCPM_DUTY_LO_LSB];
         unit_mode_select     <= reg_wdata[`CCPM_SEL_MSB:`CCPM_SEL_LSB];
      end
   end

   // Plain data registers.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         duty_high_byte <= `CCPM_RST_BYTE;
         period_reg     <= `CCPM_RST_PERIOD;
         drv_en_reg     <= `CCPM_RST_NIBBLE;
         port_data_reg  <= `CCPM_RST_NIBBLE;
         deadband_reg   <= 7'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `CCPM_OFS_DUTY_HIGH: duty_high_byte <= reg_wdata;
            `CCPM_OFS_PERIOD:    period_reg     <= reg_wdata;
            `CCPM_OFS_DRV_EN:    drv_en_reg     <= reg_wdata[3:0];
            `CCPM_OFS_PORT_DATA: port_data_reg  <= reg_wdata[3:0];
            `CCPM_OFS_DEADBAND:  deadband_reg   <= reg_wdata[6:0];
            default:             ;
         endcase
      end
   end

   // Compare value, overwritten by the timer on capture.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmp_val_reg <= 16'h0000;
      end else if (cap_event) begin
         cmp_val_reg <= tmr_reg;
      end else if (reg_wr && (reg_addr == `CCPM_OFS_CMP_LOW)) begin
         cmp_val_reg[7:0] <= reg_wdata;
      end else if (reg_wr && (reg_addr == `CCPM_OFS_CMP_HIGH)) begin
         cmp_val_reg[15:8] <= reg_wdata;
      end
   end

   // Capture and compare timer.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tmr_reg <= 16'h0000;
      end else if (unit_mode_select == `CCPM_M_OFF) begin
         tmr_reg <= 16'h0000;
      end else if (cmp_match && (unit_mode_select == `CCPM_M_CMP_TRIG)) begin
         tmr_reg <= 16'h0000;
      end else if (is_capture || is_compare) begin
         tmr_reg <= tmr_reg + 16'h0001;
      end
   end

   // Converter start pulse, one cycle per trigger match while adc_enable is set.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= cmp_match && (unit_mode_select == `CCPM_M_CMP_TRIG) &&
                      adc_enable;
      end
   end

   // Input synchroniser and edge history.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_sync1_reg <= 1'b0;
         pin_sync2_reg <= 1'b0;
         pin_prev_reg  <= 1'b0;
      end else begin
         pin_sync1_reg <= output_a_i;
         pin_sync2_reg <= pin_sync1_reg;
         pin_prev_reg  <= pin_sync2_reg;
      end
   end

   // Capture prescaler, cleared on any mode write so counting starts fresh.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cap_cnt_reg <= 4'h0;
      end else if (wr_mode || (unit_mode_select == `CCPM_M_OFF)) begin
         cap_cnt_reg <= 4'h0;
      end else if (cap_edge) begin
         cap_cnt_reg <= cap_cnt_reg + 4'h1;
      end
   end

   // Compare pin latch.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmp_pin_reg <= 1'b0;
      end else if (wr_mode) begin
         case (reg_wdata[3:0])
            `CCPM_M_CMP_CLR: cmp_pin_reg <= 1'b1;
            default:         cmp_pin_reg <= 1'b0;
         endcase
      end else if (cmp_match) begin
         case (unit_mode_select)
            `CCPM_M_TOGGLE:  cmp_pin_reg <= !cmp_pin_reg;
            `CCPM_M_CMP_SET: cmp_pin_reg <= 1'b1;
            `CCPM_M_CMP_CLR: cmp_pin_reg <= 1'b0;
            default:         ;
         endcase
      end
   end

   // Event flag; a new event in the clearing cycle keeps the flag set.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         unit_event_flag <= 1'b0;
      end else if (cmp_event || cap_event) begin
         unit_event_flag <= 1'b1;
      end else if (clr_event) begin
         unit_event_flag <= 1'b0;
      end
   end

   // PWM time base, held at zero outside PWM.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pwm_cnt_reg <= 10'h000;
      end else if (!is_pwm || pwm_roll) begin
         pwm_cnt_reg <= 10'h000;
      end else begin
         pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
      end
   end

   // In PWM, duty is taken only at a period boundary so no cycle gets a torn value.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         duty_act_reg <= 10'h000;
      end else if (!is_pwm || pwm_roll) begin
         duty_act_reg <= duty_full;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pwm_raw_reg <= 1'b0;
      end else if (!is_pwm) begin
         pwm_raw_reg <= 1'b0;
      end else if (pwm_roll) begin
         pwm_raw_reg <= (duty_full != 10'h000);
      end else begin
         pwm_raw_reg <= ((pwm_cnt_reg + 10'h001) < duty_act_reg);
      end
   end

   // The first rollover after entering PWM is the start of the second period.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         period_timer_flag <= 1'b0;
      end else if (pwm_roll) begin
         period_timer_flag <= 1'b1;
      end else if (clr_period) begin
         period_timer_flag <= 1'b0;
      end
   end

   // Dead band: both half-bridge outputs idle for the count after each edge.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         db_cnt_reg <= 7'h00;
      end else if (!is_pwm) begin
         db_cnt_reg <= 7'h00;
      end else if (pwm_raw_reg != raw_prev_reg) begin
         db_cnt_reg <= (deadband_reg != 7'h00) ? deadband_reg - 7'h01 : 7'h00;
      end else if (db_cnt_reg != 7'h00) begin
         db_cnt_reg <= db_cnt_reg - 7'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         raw_prev_reg <= 1'b0;
      end else begin
         raw_prev_reg <= pwm_raw_reg;
      end
   end

   // Delay is counted in clock cycles; zero gives plain complementary outputs.
   logic db_hold;
   logic [6:0] db_left;

   assign db_left = (pwm_raw_reg != raw_prev_reg) ? deadband_reg : db_cnt_reg;
   assign db_hold = (db_left != 7'h00);
   assign act_a   = pwm_raw_reg && !db_hold;
   assign act_b   = !pwm_raw_reg && !db_hold;

   // Steering of the unit onto the four pins, before polarity.
   always_comb begin
      unit_own = 4'h0;
      unit_val = 4'h0;
      if (is_pwm) begin
         case (ccpm_outcfg_e'(output_config_select))
            CCPM_OUT_SINGLE: begin
               unit_own = 4'h1;
               unit_val = {3'h0, pwm_raw_reg};
            end
            CCPM_OUT_FB_FWD: begin
               unit_own = 4'hf;
               unit_val = {pwm_raw_reg, 1'b0, 1'b0, 1'b1};
            end
            CCPM_OUT_HALF: begin
               unit_own = 4'h3;
               unit_val = {2'h0, act_b, act_a};
            end
            CCPM_OUT_FB_REV: begin
               unit_own = 4'hf;
               unit_val = {1'b0, 1'b1, pwm_raw_reg, 1'b0};
            end
            default: begin
               unit_own = 4'h0;
               unit_val = 4'h0;
            end
         endcase
      end else if (is_cmp_pin) begin
         unit_own = 4'h1;
         unit_val = {3'h0, cmp_pin_reg};
      end
   end

   // Pin outputs; port data where the unit does not own the pin.
   always_comb begin
      output_a_o = unit_own[0] ? (unit_val[0] ^ (is_pwm && pol_ac_low)) :
                                 port_data_reg[0];
      output_b_o = unit_own[1] ? (unit_val[1] ^ pol_bd_low) : port_data_reg[1];
      output_c_o = unit_own[2] ? (unit_val[2] ^ pol_ac_low) : port_data_reg[2];
      output_d_o = unit_own[3] ? (unit_val[3] ^ pol_bd_low) : port_data_reg[3];
   end

   // Drivers stay off from reset until software enables them.
   assign output_a_oe = drv_en_reg[0];
   assign output_b_oe = drv_en_reg[1];
   assign output_c_oe = drv_en_reg[2];
   assign output_d_oe = drv_en_reg[3];

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            `CCPM_OFS_MODE:      reg_rdata <= {output_config_select, duty_low_bits,
                                               unit_mode_select};
            `CCPM_OFS_DUTY_HIGH: reg_rdata <= duty_high_byte;
            `CCPM_OFS_CMP_LOW:   reg_rdata <= cmp_val_reg[7:0];
            `CCPM_OFS_CMP_HIGH:  reg_rdata <= cmp_val_reg[15:8];
            `CCPM_OFS_PERIOD:    reg_rdata <= period_reg;
            `CCPM_OFS_STATUS:    reg_rdata <= {6'h00, period_timer_flag, unit_event_flag};
            `CCPM_OFS_DRV_EN:    reg_rdata <= {4'h0, drv_en_reg};
            `CCPM_OFS_PORT_DATA: reg_rdata <= {4'h0, port_data_reg};
            `CCPM_OFS_DEADBAND:  reg_rdata <= {1'b0, deadband_reg};
            `CCPM_OFS_TMR_LOW:   reg_rdata <= tmr_reg[7:0];
            `CCPM_OFS_TMR_HIGH:  reg_rdata <= tmr_reg[15:8];
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule // ccpm_mode_output_config

// ### ccpm_checker_assertions.sv
// Concurrent checks on the ports of the mode and output unit.
`timescale 1ns/100ps
`include "ccpm_cfg.svh"
module ccpm_checker (
   // Clock, reset and register port.
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Converter trigger.
   input wire logic       adc_enable,
   input wire logic       adc_start,
   // Unit pins.
   input wire logic       output_a_o,
   input wire logic       output_b_o,
   input wire logic       output_c_o,
   input wire logic       output_d_o,
   input wire logic       output_a_oe,
   input wire logic       output_b_oe,
   input wire logic       output_c_oe,
   input wire logic       output_d_oe
);
   logic [7:0] mode_reg;
   logic [3:0] port_reg;
   logic [3:0] oe_all;
   logic       pwm_on;

   // Shadow copies let pin checks follow writes without peeking inside.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= 8'h00;
         port_reg <= 4'h0;
      end else if (reg_wr && reg_addr == `CCPM_OFS_MODE) begin
         mode_reg <= reg_wdata;
      end else if (reg_wr && reg_addr == `CCPM_OFS_PORT_DATA) begin
         port_reg <= reg_wdata[3:0];
      end
   end
   assign oe_all = {output_d_oe, output_c_oe, output_b_oe, output_a_oe};
   assign pwm_on = mode_reg[3:2] == 2'h3;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_rdata_stands: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_mode_readback: assert property (reg_rd && reg_addr == `CCPM_OFS_MODE |=>
      reg_rdata == mode_reg)
      else $error("mode register read back wrong");
   a_adc_cause: assert property (adc_start |->
      $past(adc_enable) && $past(mode_reg[3:0]) == 4'hb)
      else $error("converter start without cause");
   a_drive_write: assert property (reg_wr && reg_addr == `CCPM_OFS_DRV_EN |=>
      oe_all == $past(reg_wdata[3:0]))
      else $error("drive enables not taken");
   a_drive_hold: assert property (!(reg_wr && reg_addr == `CCPM_OFS_DRV_EN) |=>
      $stable(oe_all))
      else $error("drive enables changed alone");
   a_outside_port: assert property (!pwm_on |->
      {output_d_o, output_c_o, output_b_o} == port_reg[3:1])
      else $error("pins b to d not port outside pwm");
   a_a_port: assert property (!pwm_on &&
      !(mode_reg[3:0] inside {4'h2, 4'h8, 4'h9}) |-> output_a_o == port_reg[0])
      else $error("pin a not port");
   a_single_port: assert property (pwm_on && mode_reg[7:6] == 2'h0 |->
      {output_d_o, output_c_o, output_b_o} == port_reg[3:1])
      else $error("single output pins not port");
   a_half_port: assert property (pwm_on && mode_reg[7:6] == 2'h2 |->
      {output_d_o, output_c_o} == port_reg[3:2])
      else $error("half bridge c d not port");
   a_fwd_static: assert property (pwm_on && mode_reg[7:6] == 2'h1 &&
      $stable(mode_reg) |-> output_a_o == !mode_reg[1] && output_b_o == mode_reg[0] &&
      output_c_o == mode_reg[1])
      else $error("forward static pins wrong");
   a_rev_static: assert property (pwm_on && mode_reg[7:6] == 2'h3 &&
      $stable(mode_reg) |-> output_c_o == !mode_reg[1] && output_a_o == mode_reg[1] &&
      output_d_o == mode_reg[0])
      else $error("reverse static pins wrong");
   a_cmp_init: assert property (reg_wr && reg_addr == `CCPM_OFS_MODE &&
      reg_wdata[3:1] == 3'h4 |=> output_a_o == $past(reg_wdata[0]))
      else $error("compare pin start level wrong");

   c_trigger: cover property (adc_start);
   c_half: cover property (pwm_on && mode_reg[7:6] == 2'h2 && output_b_oe);
   c_reverse: cover property (pwm_on && mode_reg[7:6] == 2'h3 && output_b_oe);
endmodule // ccpm_checker

// ### ccpm_bridge_model.sv
// Bridge driver model: pull-downs on the four unit pins and a capture source on pin A.
`timescale 1ns/100ps
module ccpm_bridge_model (
   // Unit pin outputs and enables.
   input  wire logic [3:0] pin_o,
   input  wire logic [3:0] pin_oe,
   // Capture source on pin A.
   input  wire logic       ext_en,
   input  wire logic       ext_val,
   // Resolved pin levels.
   output logic      [3:0] pin_lvl
);
   // Released pins fall to the pull-down, except pin A while the capture source drives it, so the switches stay off until driven.
   always_comb begin
      pin_lvl = pin_oe & pin_o;
      if (!pin_oe[0] && ext_en)
         pin_lvl[0] = ext_val;
   end
endmodule // ccpm_bridge_model

// ### ccpm_mode_output_config_tb.sv
// Self-checking bench for the mode and output unit.
`timescale 1ns/100ps
`include "ccpm_cfg.svh"
module ccpm_mode_output_config_tb;
   logic       ref_clk, resetn, reg_wr, reg_rd, adc_enable, adc_start, ext_en, ext_val;
   logic [3:0] reg_addr, pin_o, pin_oe, pin_lvl;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   int         n_fail, total_checks;

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   ccpm_mode_output_config #(.ENHANCED(1'b1)) ccpm_mode_output_config_inst (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_enable(adc_enable),
      .adc_start(adc_start), .output_a_i(pin_lvl[0]), .output_a_o(pin_o[0]),
      .output_a_oe(pin_oe[0]), .output_b_o(pin_o[1]), .output_b_oe(pin_oe[1]),
      .output_c_o(pin_o[2]), .output_c_oe(pin_oe[2]), .output_d_o(pin_o[3]),
      .output_d_oe(pin_oe[3]));
   ccpm_bridge_model ccpm_bridge_model_inst (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_lvl(pin_lvl));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Select 0 to 3 is a pin output, 4 the converter start; n counts edges waited minus one.
   task automatic wait_for(input int sel, input logic v, output int n);
      logic [4:0] s;
      for (n = 0; n < 200; n++) begin
         @(posedge ref_clk);
         #1;
         s = {adc_start, pin_o};
         if (s[sel] === v)
            return;
      end
      chk(1'b0, 1'b1);
      end_of_test();
   endtask
   task automatic pwm_count(input int sel, input logic inv, output int n);
      n = 0;
      repeat (16) begin
         @(posedge ref_clk);
         #1;
         n += int'(pin_lvl[sel] ^ inv);
      end
   endtask

   task automatic t_regs();
      rd(`CCPM_OFS_MODE);
      chk(rd_val, 8'h00);
      chk(pin_oe, 4'h0);
      rd(4'hf);
      chk(rd_val, 8'h00);
      wr(`CCPM_OFS_MODE, 8'hb7);
      rd(`CCPM_OFS_MODE);
      chk(rd_val, 8'hb7);
      wr(`CCPM_OFS_PORT_DATA, 8'h05);
      wr(`CCPM_OFS_MODE, 8'h00);
      wr(`CCPM_OFS_MODE, 8'h03);
      repeat (20) @(posedge ref_clk);
      rd(`CCPM_OFS_TMR_LOW);
      chk(rd_val, 8'h00);
      chk(pin_o[0], 1'b1);
   endtask
   task automatic t_compare();
      int n;
      wr(`CCPM_OFS_CMP_LOW, 8'h14);
      wr(`CCPM_OFS_CMP_HIGH, 8'h00);
      wr(`CCPM_OFS_DRV_EN, 8'h01);
      for (int m = 8; m < 11; m++) begin
         wr(`CCPM_OFS_MODE, 8'h00);
         wr(`CCPM_OFS_STATUS, 8'h03);
         wr(`CCPM_OFS_MODE, m[7:0]);
         #1;
         if (m < 10)
            chk(pin_o[0], m[0]);
         if (m < 10)
            wait_for(0, !m[0], n);
         repeat (30) @(posedge ref_clk);
         rd(`CCPM_OFS_STATUS);
         chk(rd_val[0], 1'b1);
         chk(pin_o[0], m == 10 ? 1'b1 : !m[0]);
      end
      wr(`CCPM_OFS_MODE, 8'h00);
      wr(`CCPM_OFS_MODE, 8'h02);
      wait_for(0, 1'b1, n);
      wr(`CCPM_OFS_MODE, 8'h00);
      rd(`CCPM_OFS_TMR_LOW);
      chk(rd_val, 8'h00);
   endtask
   task automatic t_trigger();
      int n;
      adc_enable <= 1'b1;
      wr(`CCPM_OFS_CMP_LOW, 8'h0a);
      wr(`CCPM_OFS_MODE, 8'h0b);
      wait_for(4, 1'b1, n);
      wait_for(4, 1'b1, n);
      chk(n[15:0], 16'h000a);
      adc_enable <= 1'b0;
      wr(`CCPM_OFS_STATUS, 8'h03);
      repeat (30) begin
         @(posedge ref_clk);
         #1;
         chk(adc_start, 1'b0);
      end
      rd(`CCPM_OFS_STATUS);
      chk(rd_val[0], 1'b1);
      wr(`CCPM_OFS_MODE, 8'h00);
   endtask
   task automatic t_capture();
      int edges [4] = '{1, 1, 4, 16};
      wr(`CCPM_OFS_DRV_EN, 8'h00);
      ext_en <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(`CCPM_OFS_MODE, 8'h00);
         wr(`CCPM_OFS_STATUS, 8'h03);
         wr(`CCPM_OFS_MODE, 8'h04 + k[7:0]);
         for (int e = 0; e < edges[k]; e++) begin
            rd(`CCPM_OFS_STATUS);
            chk(rd_val[0], 1'b0);
            ext_val <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_val <= 1'b0;
            repeat (4) @(posedge ref_clk);
         end
         rd(`CCPM_OFS_STATUS);
         chk(rd_val[0], 1'b1);
      end
      ext_en <= 1'b0;
   endtask
   task automatic t_pwm();
      int n;
      int sel_t [4] = '{0, 3, 0, 1};
      wr(`CCPM_OFS_PERIOD, 8'h03);
      wr(`CCPM_OFS_DUTY_HIGH, 8'h02);
      wr(`CCPM_OFS_DEADBAND, 8'h02);
      wr(`CCPM_OFS_MODE, 8'h00);
      wr(`CCPM_OFS_STATUS, 8'h03);
      wr(`CCPM_OFS_MODE, 8'h1c);
      rd(`CCPM_OFS_STATUS);
      chk(rd_val[1], 1'b0);
      repeat (16) @(posedge ref_clk);
      rd(`CCPM_OFS_STATUS);
      chk(rd_val[1], 1'b1);
      // Drivers go off before each change of shape or polarity and back on after 32 idle cycles.
      for (int c = 0; c < 4; c++) begin
         for (int p = 0; p < 4; p++) begin
            wr(`CCPM_OFS_DRV_EN, 8'h00);
            wr(`CCPM_OFS_MODE, {c[1:0], 2'b01, 2'b11, p[1:0]});
            repeat (32) @(posedge ref_clk);
            wr(`CCPM_OFS_DRV_EN, 8'h0f);
            pwm_count(sel_t[c], sel_t[c] == 0 ? p[1] : p[0], n);
            chk(n[15:0], c == 2 ? 16'h0007 : 16'h0009);
            if (c == 2)
               pwm_count(1, p[0], n);
            if (c == 2)
               chk(n[15:0], 16'h0005);
         end
      end
      wr(`CCPM_OFS_MODE, 8'h00);
   endtask

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      adc_enable = 1'b0;
      ext_en = 1'b0;
      ext_val = 1'b0;
      n_fail = 0;
      total_checks = 0;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_compare();
      t_trigger();
      t_capture();
      t_pwm();
      end_of_test();
   end
endmodule // ccpm_mode_output_config_tb

bind ccpm_mode_output_config ccpm_checker ccpm_checker_inst (.ref_clk(ref_clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .adc_enable(adc_enable), .adc_start(adc_start),
   .output_a_o(output_a_o), .output_b_o(output_b_o), .output_c_o(output_c_o),
   .output_d_o(output_d_o), .output_a_oe(output_a_oe), .output_b_oe(output_b_oe),
   .output_c_oe(output_c_oe), .output_d_oe(output_d_oe));
